/* src/csd_pkg.sv */
package csd_pkg;
  // Register offsets on the serial register port
  localparam logic [5:0] CSD_OFS_GAIN_RED  = 6'h2d;
  localparam logic [5:0] CSD_OFS_CAPS_CTRL = 6'h2e;
  localparam logic [5:0] CSD_OFS_CAPS_RES  = 6'h2f;
  localparam logic [5:0] CSD_OFS_AUX_STAT  = 6'h30;

  // Reset values
  localparam logic [7:0] CSD_RST_GAIN_RED  = 8'h00;
  localparam logic [7:0] CSD_RST_CAPS_CTRL = 8'h00;
  localparam logic [7:0] CSD_RST_CAPS_RES  = 8'h00;
  localparam logic [7:0] CSD_RST_AUX_STAT  = 8'h00;

  // Field positions
  localparam int CSD_AM_MSB   = 7;
  localparam int CSD_AM_LSB   = 4;
  localparam int CSD_PM_MSB   = 3;
  localparam int CSD_PM_LSB   = 0;
  localparam int CSD_CAL_MSB  = 7;
  localparam int CSD_CAL_LSB  = 3;
  localparam int CSD_GAIN_MSB = 2;
  localparam int CSD_GAIN_LSB = 0;
  localparam int CSD_CAL_END  = 2;
  localparam int CSD_CAL_ERR  = 1;
  localparam int CSD_AUX_CHAN = 7;
  localparam int CSD_AUX_EFD  = 6;

  // Synchroniser depth for status arriving from other domains
  localparam int CSD_SYNC_STAGES = 2;

  // Capacitive sensor gain codes
  typedef enum logic [2:0] {
    CSD_GAIN_2P8  = 3'h0,
    CSD_GAIN_6P5  = 3'h1,
    CSD_GAIN_1P1  = 3'h2,
    CSD_GAIN_0P5  = 3'h4,
    CSD_GAIN_0P35 = 3'h6
  } csd_gain_t;

  // Calibration trim value of all zeros selects automatic calibration
  localparam logic [4:0] CSD_CAL_AUTO = 5'h00;
endpackage : csd_pkg

/* src/csd_stat_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface csd_stat_if;
  logic [7:0] aux_sync;

  modport src (output aux_sync);
  modport dst (input  aux_sync);
endinterface : csd_stat_if
`default_nettype wire

/* src/csd_status_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module csd_status_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Raw status from other domains
  input  wire logic [WIDTH-1:0] raw,
  // Synchronised status
  csd_stat_if.src               stat
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // Two flops per bit; first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
    end
  end

  assign stat.aux_sync = stage2;
endmodule : csd_status_sync
`default_nettype wire

/* src/csd_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module csd_regs
  import csd_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // Register port from the serial interface
  input  wire logic [5:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output var  logic [7:0] REG_RDATA,
  // Set-default command strobe
  input  wire logic       SET_DEFAULT,
  // Receive gain state, same clock
  input  wire logic [3:0] AM_GAIN_CUT_LEVEL,
  input  wire logic [3:0] PM_GAIN_CUT_LEVEL,
  // Capacitive sensor calibration result, same clock
  input  wire logic [4:0] CAL_VALUE,
  input  wire logic       CAL_DONE,
  input  wire logic       CAL_FAULT,
  // Status from other domains
  input  wire logic       CHANNEL_PM,
  input  wire logic       EXT_FIELD,
  input  wire logic       TX_ACTIVE,
  input  wire logic       OSC_STABLE,
  input  wire logic       RX_ENABLED,
  input  wire logic       RX_BUSY,
  input  wire logic       PEER_DETECT,
  input  wire logic       COLLISION_AVOID_ACTIVE,
  // Capacitive sensor configuration to the analog part
  output var  logic [4:0] CAPS_TRIM,
  output var  logic       CAPS_AUTO_CAL,
  output var  logic [2:0] CAPS_GAIN,
  output var  logic       CAPS_GAIN_BAD
);
  import csd_pkg::*;

  csd_stat_if stat ();

  logic [7:0] gain_red;
  logic [7:0] caps_ctrl;
  logic [7:0] caps_res;
  logic [7:0] aux_stat;
  logic [7:0] aux_raw;
  logic [7:0] next_gain_red;
  logic [7:0] next_caps_ctrl;
  logic [7:0] next_caps_res;
  logic [7:0] next_rdata;
  logic       wr_ctrl;
  logic       next_auto;
  logic       next_bad;

  // Gain code check
  function automatic logic gain_unused(input logic [2:0] code);
    case (code)
      CSD_GAIN_2P8, CSD_GAIN_6P5, CSD_GAIN_1P1,
      CSD_GAIN_0P5, CSD_GAIN_0P35: gain_unused = 1'b0;
      default:                     gain_unused = 1'b1;
    endcase
  endfunction : gain_unused

  // Auxiliary status pins in register bit order
  assign aux_raw = {CHANNEL_PM,
                    EXT_FIELD,
                    TX_ACTIVE,
                    OSC_STABLE,
                    RX_ENABLED,
                    RX_BUSY,
                    PEER_DETECT,
                    COLLISION_AVOID_ACTIVE};

  csd_status_sync #(
    .WIDTH (8)
  ) u_sync (
    .clk  (CLK),
    .rst  (SYS_RST),
    .raw  (aux_raw),
    .stat (stat)
  );

  // Register decode; only the control register accepts writes
  assign wr_ctrl        = REG_WR && (REG_ADDR == CSD_OFS_CAPS_CTRL);
  assign next_caps_ctrl = wr_ctrl ? REG_WDATA : caps_ctrl;
  assign next_gain_red  = {AM_GAIN_CUT_LEVEL, PM_GAIN_CUT_LEVEL};
  assign next_caps_res  = {CAL_VALUE, CAL_DONE, CAL_FAULT, 1'b0};
  assign next_auto      = next_caps_ctrl[CSD_CAL_MSB:CSD_CAL_LSB]
                          == CSD_CAL_AUTO;
  assign next_bad       =
    gain_unused(next_caps_ctrl[CSD_GAIN_MSB:CSD_GAIN_LSB]);

  // Read multiplexer, unmapped offsets read zero
  assign next_rdata =
    (REG_ADDR == CSD_OFS_GAIN_RED)  ? gain_red  :
    (REG_ADDR == CSD_OFS_CAPS_CTRL) ? caps_ctrl :
    (REG_ADDR == CSD_OFS_CAPS_RES)  ? caps_res  :
    (REG_ADDR == CSD_OFS_AUX_STAT)  ? aux_stat  : 8'h00;

  // Register bank, cleared by power-up and set-default
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gain_red  <= CSD_RST_GAIN_RED;
      caps_ctrl <= CSD_RST_CAPS_CTRL;
      caps_res  <= CSD_RST_CAPS_RES;
      aux_stat  <= CSD_RST_AUX_STAT;
    end else if (SET_DEFAULT) begin
      gain_red  <= CSD_RST_GAIN_RED;
      caps_ctrl <= CSD_RST_CAPS_CTRL;
      caps_res  <= CSD_RST_CAPS_RES;
      aux_stat  <= CSD_RST_AUX_STAT;
    end else begin
      gain_red  <= next_gain_red;
      caps_ctrl <= next_caps_ctrl;
      caps_res  <= next_caps_res;
      aux_stat  <= stat.aux_sync;
    end
  end

  // Decoded sensor configuration, held in flops
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CAPS_TRIM     <= CSD_RST_CAPS_CTRL[CSD_CAL_MSB:CSD_CAL_LSB];
      CAPS_GAIN     <= CSD_RST_CAPS_CTRL[CSD_GAIN_MSB:CSD_GAIN_LSB];
      CAPS_AUTO_CAL <= 1'b1;
      CAPS_GAIN_BAD <= 1'b0;
    end else if (SET_DEFAULT) begin
      CAPS_TRIM     <= CSD_RST_CAPS_CTRL[CSD_CAL_MSB:CSD_CAL_LSB];
      CAPS_GAIN     <= CSD_RST_CAPS_CTRL[CSD_GAIN_MSB:CSD_GAIN_LSB];
      CAPS_AUTO_CAL <= 1'b1;
      CAPS_GAIN_BAD <= 1'b0;
    end else begin
      CAPS_TRIM     <= next_caps_ctrl[CSD_CAL_MSB:CSD_CAL_LSB];
      CAPS_GAIN     <= next_caps_ctrl[CSD_GAIN_MSB:CSD_GAIN_LSB];
      CAPS_AUTO_CAL <= next_auto;
      CAPS_GAIN_BAD <= next_bad;
    end
  end

  // Read data captured on a read strobe and held until the next one
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence quiet3;
    !SET_DEFAULT [*3];
  endsequence

  sequence ctrl_write;
    REG_WR && REG_ADDR == CSD_OFS_CAPS_CTRL && !SET_DEFAULT;
  endsequence

  chk_gain_am: assert property (
    !SET_DEFAULT |=> gain_red[7:4] == $past(AM_GAIN_CUT_LEVEL))
    else $error("AM gain cut not shown");

  chk_gain_pm: assert property (
    !SET_DEFAULT |=> gain_red[3:0] == $past(PM_GAIN_CUT_LEVEL))
    else $error("PM gain cut not shown");

  chk_default_clear: assert property (
    SET_DEFAULT |=> {gain_red, caps_ctrl, caps_res, aux_stat} == 32'h0
                    && CAPS_AUTO_CAL)
    else $error("Set default did not clear registers");

  chk_ctrl_auto: assert property (
    ctrl_write ##1 1'b1 |-> CAPS_TRIM == $past(REG_WDATA[7:3])
      && CAPS_AUTO_CAL == ($past(REG_WDATA[7:3]) == 5'h00))
    else $error("Trim or auto calibration wrong");

  chk_gain_code: assert property (
    ctrl_write |=> CAPS_GAIN == $past(REG_WDATA[2:0])
      && CAPS_GAIN_BAD == !($past(REG_WDATA[2:0]) inside
         {3'h0, 3'h1, 3'h2, 3'h4, 3'h6}))
    else $error("Sensor gain decode wrong");

  chk_cal_result: assert property (
    !SET_DEFAULT |=> caps_res == {$past(CAL_VALUE), $past(CAL_DONE),
                                  $past(CAL_FAULT), 1'b0})
    else $error("Calibration result not shown");

  chk_efd_track: assert property (
    quiet3 |-> aux_stat[CSD_AUX_EFD] == $past(EXT_FIELD, 3))
    else $error("Field detector bit lags wrongly");

  chk_aux_track: assert property (
    quiet3 |-> aux_stat == $past(aux_raw, 3))
    else $error("Auxiliary status bits wrong");

  chk_ro_write: assert property (
    REG_WR && REG_ADDR == CSD_OFS_AUX_STAT && !SET_DEFAULT
      |=> caps_ctrl == $past(caps_ctrl))
    else $error("Write to display register leaked");

  chk_read_ctrl: assert property (
    REG_RD && REG_ADDR == CSD_OFS_CAPS_CTRL |=> REG_RDATA == $past(caps_ctrl))
    else $error("Control read-back wrong");
endmodule : csd_regs
`default_nettype wire

/* tb/tb_capsense_and_status_display_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_capsense_and_status_display_regs;
  import csd_pkg::*;

  // Design inputs and outputs
  logic       CLK;
  logic       SYS_RST;
  logic [5:0] REG_ADDR;
  logic       REG_WR;
  logic [7:0] REG_WDATA;
  logic       REG_RD;
  logic [7:0] REG_RDATA;
  logic       SET_DEFAULT;
  logic [3:0] AM_GAIN_CUT_LEVEL;
  logic [3:0] PM_GAIN_CUT_LEVEL;
  logic [4:0] CAL_VALUE;
  logic       CAL_DONE;
  logic       CAL_FAULT;
  logic [7:0] aux;
  logic [4:0] CAPS_TRIM;
  logic       CAPS_AUTO_CAL;
  logic [2:0] CAPS_GAIN;
  logic       CAPS_GAIN_BAD;
  // Bench bookkeeping
  int         failures;
  int         compares;
  logic [2:0] gains [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
  logic [4:0] trims [5] = '{5'h00, 5'h1f, 5'h01, 5'h10, 5'h0a};

  csd_regs i_csd_regs (
    .CLK                    (CLK),
    .SYS_RST                (SYS_RST),
    .REG_ADDR               (REG_ADDR),
    .REG_WR                 (REG_WR),
    .REG_WDATA              (REG_WDATA),
    .REG_RD                 (REG_RD),
    .REG_RDATA              (REG_RDATA),
    .SET_DEFAULT            (SET_DEFAULT),
    .AM_GAIN_CUT_LEVEL      (AM_GAIN_CUT_LEVEL),
    .PM_GAIN_CUT_LEVEL      (PM_GAIN_CUT_LEVEL),
    .CAL_VALUE              (CAL_VALUE),
    .CAL_DONE               (CAL_DONE),
    .CAL_FAULT              (CAL_FAULT),
    .CHANNEL_PM             (aux[7]),
    .EXT_FIELD              (aux[6]),
    .TX_ACTIVE              (aux[5]),
    .OSC_STABLE             (aux[4]),
    .RX_ENABLED             (aux[3]),
    .RX_BUSY                (aux[2]),
    .PEER_DETECT            (aux[1]),
    .COLLISION_AVOID_ACTIVE (aux[0]),
    .CAPS_TRIM              (CAPS_TRIM),
    .CAPS_AUTO_CAL          (CAPS_AUTO_CAL),
    .CAPS_GAIN              (CAPS_GAIN),
    .CAPS_GAIN_BAD          (CAPS_GAIN_BAD)
  );

  // Clock at 50 ns period
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge CLK);
    #5;
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = 1'b1;
    @(posedge CLK);
    #5;
    REG_WR = 1'b0;
  endtask : wr

  // One-cycle read strobe, also ends any set-default pulse
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge CLK);
    #5;
    SET_DEFAULT = 1'b0;
    REG_ADDR    = a;
    REG_RD      = 1'b1;
    @(posedge CLK);
    #5;
    REG_RD = 1'b0;
    chk(REG_RDATA, exp);
  endtask : rd

  // Set-default pulse followed directly by a read
  task automatic dflt_rd(input logic [5:0] a);
    @(posedge CLK);
    #5;
    SET_DEFAULT = 1'b1;
    rd(a, 8'h00);
  endtask : dflt_rd

  // Print counts and verdict, then stop
  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // Watchdog well beyond the expected run
  initial begin
    #200us;
    failures++;
    summarize();
  end

  // Main sequence
  initial begin
    failures          = 0;
    compares          = 0;
    SYS_RST           = 1'b1;
    REG_ADDR          = 6'h00;
    REG_WR            = 1'b0;
    REG_WDATA         = 8'h00;
    REG_RD            = 1'b0;
    SET_DEFAULT       = 1'b0;
    AM_GAIN_CUT_LEVEL = 4'h0;
    PM_GAIN_CUT_LEVEL = 4'h0;
    CAL_VALUE         = 5'h00;
    CAL_DONE          = 1'b0;
    CAL_FAULT         = 1'b0;
    aux               = 8'h00;
    repeat (5) @(posedge CLK);
    #5;
    SYS_RST = 1'b0;
    for (int a = 8'h2d; a <= 8'h30; a++) rd(a[5:0], 8'h00);
    chk({7'h00, CAPS_AUTO_CAL}, 8'h01);
    AM_GAIN_CUT_LEVEL = 4'ha;
    PM_GAIN_CUT_LEVEL = 4'h5;
    CAL_VALUE = 5'h13;
    CAL_DONE  = 1'b1;
    rd(CSD_OFS_GAIN_RED, 8'ha5);
    rd(CSD_OFS_CAPS_RES, 8'h9c);
    CAL_DONE  = 1'b0;
    CAL_FAULT = 1'b1;
    rd(CSD_OFS_CAPS_RES, 8'h9a);
    // Walk a single one through every status bit
    for (int i = 0; i < 8; i++) begin
      aux = 8'h01 << i;
      repeat (4) @(posedge CLK);
      rd(CSD_OFS_AUX_STAT, aux);
    end
    // Every used gain code with a spread of trim values
    for (int i = 0; i < 5; i++) begin
      wr(CSD_OFS_CAPS_CTRL, {trims[i], gains[i]});
      rd(CSD_OFS_CAPS_CTRL, {trims[i], gains[i]});
      chk({CAPS_TRIM, CAPS_GAIN}, {trims[i], gains[i]});
      chk({7'h00, CAPS_AUTO_CAL}, {7'h00, trims[i] == 5'h00});
      chk({7'h00, CAPS_GAIN_BAD}, 8'h00);
    end
    wr(CSD_OFS_CAPS_CTRL, 8'hfb);
    chk({7'h00, CAPS_GAIN_BAD}, 8'h01);
    // Writes to display and unmapped places are ignored
    wr(CSD_OFS_GAIN_RED, 8'h00);
    wr(CSD_OFS_CAPS_RES, 8'hff);
    wr(CSD_OFS_AUX_STAT, 8'h00);
    wr(6'h3f, 8'h5a);
    rd(CSD_OFS_GAIN_RED, 8'ha5);
    rd(CSD_OFS_CAPS_RES, 8'h9a);
    rd(CSD_OFS_AUX_STAT, 8'h80);
    rd(6'h3f, 8'h00);
    rd(CSD_OFS_CAPS_CTRL, 8'hfb);
    // Set-default clears all four while the sources stay busy
    dflt_rd(CSD_OFS_GAIN_RED);
    dflt_rd(CSD_OFS_CAPS_RES);
    dflt_rd(CSD_OFS_AUX_STAT);
    wr(CSD_OFS_CAPS_CTRL, 8'hfb);
    dflt_rd(CSD_OFS_CAPS_CTRL);
    chk({CAPS_TRIM, CAPS_GAIN}, 8'h00);
    chk({7'h00, CAPS_AUTO_CAL}, 8'h01);
    chk({7'h00, CAPS_GAIN_BAD}, 8'h00);
    rd(CSD_OFS_GAIN_RED, 8'ha5);
    summarize();
  end
endmodule : tb_capsense_and_status_display_regs
`default_nettype wire
